// ### rtl/port_rail_pkg.sv
// package for the usb port and rail control block
// assumes a single 250 MHz clock domain and an apb register slave
package port_rail_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  // register byte offsets
  localparam logic [7:0]  OFF_RAIL_EN     = 8'h00;
  localparam logic [7:0]  OFF_REG_SEL     = 8'h04;
  localparam logic [7:0]  OFF_REG_STATE   = 8'h08;
  localparam logic [7:0]  OFF_TEMP        = 8'h0C;
  localparam logic [7:0]  OFF_SETPT_A     = 8'h10;
  localparam logic [7:0]  OFF_SETPT_B     = 8'h14;
  localparam logic [7:0]  OFF_SERIAL_EN   = 8'h18;
  localparam logic [7:0]  OFF_CHAN_CMD    = 8'h1C;
  localparam logic [7:0]  OFF_HUB_MODE    = 8'h20;
  localparam logic [7:0]  OFF_UP_SEL      = 8'h24;
  localparam logic [7:0]  OFF_UP_STATE    = 8'h28;
  localparam logic [7:0]  OFF_CHAN_STATE0 = 8'h30;
  localparam logic [7:0]  OFF_RAIL_STAT   = 8'h40;
  // regulator selection codes
  localparam logic [1:0]  REG_SEL_AUTO    = 2'h0;
  localparam logic [1:0]  REG_SEL_LINEAR  = 2'h1;
  localparam logic [1:0]  REG_SEL_SWITCH  = 2'h2;
  localparam logic [7:0]  REG_ACT_LINEAR  = 8'h00;
  localparam logic [7:0]  REG_ACT_SWITCH  = 8'h01;
  localparam int          REG_STATE_LSB   = 8;
  // upstream selection codes
  localparam logic [1:0]  UP_SEL_EDGE     = 2'h0;
  localparam logic [1:0]  UP_SEL_MINIB    = 2'h1;
  localparam logic [1:0]  UP_SEL_AUTO     = 2'h2;
  // auto threshold 7.25 V, input voltage given in millivolts
  localparam logic [15:0] AUTO_THRESH_MV  = 16'h1C52;
  // channel command field layout
  localparam int          CMD_CHAN_LSB    = 0;
  localparam int          CMD_TARGET_LSB  = 4;
  localparam int          CMD_ON_BIT      = 8;
  localparam logic [1:0]  TGT_VBUS        = 2'h1;
  localparam logic [1:0]  TGT_DATA        = 2'h2;
  localparam logic [1:0]  TGT_BOTH        = 2'h3;
  // channel state word fields
  localparam int          CST_VBUS_BIT    = 0;
  localparam int          CST_DATA_BIT    = 1;
  localparam int          CST_ERR_BIT     = 19;
  localparam int          CST_BOOST_BIT   = 20;
  // reset values
  localparam logic [2:0]  RAIL_EN_RST     = 3'h0;
  localparam logic [3:0]  SERIAL_EN_RST   = 4'h0;
  localparam logic [7:0]  HUB_MODE_RST    = 8'h00;
  localparam logic [31:0] SETPT_RST       = 32'h0000_0000;
endpackage

// ### rtl/port_rail_ctrl.sv
// usb port and rail control: apb registers, rail, serial and usb switching
// assumes synchronous status inputs and a standard apb master
// Operation
// - each of three rails switched by host
// - regulator select code, auto default, readable
// - auto picks switcher above 7.25 V
// - state word bits 8-15 show regulator used
// - board temperature readable by host
// - over-temperature holds linear regulator off
// - adjustable rail setpoints in microvolts, readable
// - over-voltage disconnects rail until it clears
// - each serial port has own enable
// - serial 0,1 on rail a; 2,3 on b
// - disabled serial port lines pulled to ground
// - per channel vbus, data or both commands
// - two extra usb channels always on
// - controlled ports configured as standard data ports
// - upstream select code, auto default, readable
// - auto upstream uses mini-b when vbus present
// - upstream in use readable separately
// - hub mode word packs all channel enables
// - each channel has readable state word
// - state word vbus, data, error, boost bits
module port_rail_ctrl
  import port_rail_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int SERIALS  = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       inputMillivolts,
  input  wire logic [31:0]       boardTemperature,
  input  wire logic              overTemperature,
  input  wire logic [1:0]        overVoltage,
  input  wire logic              miniBVbusPresent,
  input  wire logic [3:0]        channelError,
  input  wire logic [3:0]        channelBoost,
  output logic      [2:0]        railEnable,
  output logic                   linearRegEnable,
  output logic                   switchRegEnable,
  output logic      [31:0]       railSetpointA,
  output logic      [31:0]       railSetpointB,
  output logic      [3:0]        serialEnable,
  output logic      [3:0]        serialDischarge,
  output logic      [3:0]        serialRailSelect,
  output logic      [3:0]        vbusEnable,
  output logic      [3:0]        dataEnable,
  output logic      [3:0]        standardDataPort,
  output logic                   edgeDownEnable,
  output logic                   typeADownEnable,
  output logic                   upstreamMiniB
);
  if (CHANNELS != 4 || SERIALS != 4) begin : g_size_check
    $error("only four channels and four serial ports");
  end

  typedef struct packed {
    logic [2:0]  railEn;
    logic [1:0]  regSel;
    logic        useSwitch;
    logic [31:0] setA;
    logic [31:0] setB;
    logic [3:0]  serEn;
    logic [7:0]  hub_port_mode_word;
    logic [1:0]  upSel;
    logic        upMiniB;
    logic [31:0] rdata;
    logic        ackPend;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;

  logic        access;
  logic        wr;
  logic [1:0]  cmdChan;
  logic [1:0]  cmdTgt;
  logic        cmdOn;
  logic [31:0] chanState [4];

  assign access  = psel && penable;
  // a write lands only at the edge where the master sees pready high
  assign wr      = access && pwrite && cur_r.ackPend;
  assign cmdChan = pwdata[CMD_CHAN_LSB +: 2];
  assign cmdTgt  = pwdata[CMD_TARGET_LSB +: 2];
  assign cmdOn   = pwdata[CMD_ON_BIT];

  for (genvar c = 0; c < 4; c++) begin : g_chan
    always_comb begin
      chanState[c]                = 32'h0000_0000;
      chanState[c][CST_VBUS_BIT]  = cur_r.hub_port_mode_word[2*c+1];
      chanState[c][CST_DATA_BIT]  = cur_r.hub_port_mode_word[2*c];
      chanState[c][CST_ERR_BIT]   = channelError[c];
      chanState[c][CST_BOOST_BIT] = channelBoost[c];
    end
  end

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.ackPend = access && !cur_r.ackPend;
    // regulator choice is re-evaluated every cycle
    case (cur_r.regSel)
      REG_SEL_LINEAR: cur_nxt.useSwitch = 1'b0;
      REG_SEL_SWITCH: cur_nxt.useSwitch = 1'b1;
      default:        cur_nxt.useSwitch = inputMillivolts > AUTO_THRESH_MV;
    endcase
    case (cur_r.upSel)
      UP_SEL_EDGE:  cur_nxt.upMiniB = 1'b0;
      UP_SEL_MINIB: cur_nxt.upMiniB = 1'b1;
      default:      cur_nxt.upMiniB = miniBVbusPresent;
    endcase
    if (wr) begin
      case (paddr)
        OFF_RAIL_EN:   cur_nxt.railEn = pwdata[2:0];
        OFF_REG_SEL: begin
          // an undefined code is refused, the old selection stays
          if (pwdata[1:0] != 2'h3) cur_nxt.regSel = pwdata[1:0];
        end
        OFF_SETPT_A:   cur_nxt.setA = pwdata;
        OFF_SETPT_B:   cur_nxt.setB = pwdata;
        OFF_SERIAL_EN: cur_nxt.serEn = pwdata[3:0];
        OFF_CHAN_CMD: begin
          if (cmdTgt[0]) cur_nxt.hub_port_mode_word[2*cmdChan+1] = cmdOn;
          if (cmdTgt[1]) cur_nxt.hub_port_mode_word[2*cmdChan]   = cmdOn;
        end
        OFF_HUB_MODE:  cur_nxt.hub_port_mode_word = pwdata[7:0];
        OFF_UP_SEL: begin
          if (pwdata[1:0] != 2'h3) cur_nxt.upSel = pwdata[1:0];
        end
        default:       ; // unmapped and read-only offsets ignore writes
      endcase
    end
    cur_nxt.rdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (paddr)
        OFF_RAIL_EN:     cur_nxt.rdata[2:0] = cur_r.railEn;
        OFF_REG_SEL:     cur_nxt.rdata[1:0] = cur_r.regSel;
        OFF_REG_STATE:   cur_nxt.rdata[REG_STATE_LSB +: 8] =
                           cur_r.useSwitch ? REG_ACT_SWITCH : REG_ACT_LINEAR;
        OFF_TEMP:        cur_nxt.rdata = boardTemperature;
        OFF_SETPT_A:     cur_nxt.rdata = cur_r.setA;
        OFF_SETPT_B:     cur_nxt.rdata = cur_r.setB;
        OFF_SERIAL_EN:   cur_nxt.rdata[3:0] = cur_r.serEn;
        OFF_CHAN_CMD:    cur_nxt.rdata = 32'h0000_0000;
        OFF_HUB_MODE:    cur_nxt.rdata[7:0] = cur_r.hub_port_mode_word;
        OFF_UP_SEL:      cur_nxt.rdata[1:0] = cur_r.upSel;
        OFF_UP_STATE:    cur_nxt.rdata[0] = cur_r.upMiniB;
        OFF_CHAN_STATE0: cur_nxt.rdata = chanState[0];
        OFF_CHAN_STATE0 + 8'h04: cur_nxt.rdata = chanState[1];
        OFF_CHAN_STATE0 + 8'h08: cur_nxt.rdata = chanState[2];
        OFF_CHAN_STATE0 + 8'h0C: cur_nxt.rdata = chanState[3];
        OFF_RAIL_STAT:   cur_nxt.rdata[3:0] = {overVoltage, overTemperature, cur_r.useSwitch};
        default:         cur_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cur_r.railEn    <= RAIL_EN_RST;
      cur_r.regSel    <= REG_SEL_AUTO;
      cur_r.useSwitch <= 1'b0;
      cur_r.setA      <= SETPT_RST;
      cur_r.setB      <= SETPT_RST;
      cur_r.serEn     <= SERIAL_EN_RST;
      cur_r.hub_port_mode_word   <= HUB_MODE_RST;
      cur_r.upSel     <= UP_SEL_AUTO;
      cur_r.upMiniB   <= 1'b0;
      cur_r.rdata     <= 32'h0000_0000;
      cur_r.ackPend   <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // read data is registered, so every access takes one wait cycle
  assign pready  = cur_r.ackPend;
  assign pslverr = 1'b0;
  assign prdata  = cur_r.rdata;

  // rail b and a gated off by over-voltage, back on once it clears
  assign railEnable[0]    = cur_r.railEn[0];
  assign railEnable[1]    = cur_r.railEn[1] && !overVoltage[0];
  assign railEnable[2]    = cur_r.railEn[2] && !overVoltage[1];
  assign linearRegEnable  = cur_r.railEn[0] && !cur_r.useSwitch && !overTemperature;
  assign switchRegEnable  = cur_r.railEn[0] && cur_r.useSwitch;
  assign railSetpointA    = cur_r.setA;
  assign railSetpointB    = cur_r.setB;
  assign serialEnable     = cur_r.serEn;
  assign serialDischarge  = ~cur_r.serEn;
  assign serialRailSelect = 4'hC;
  for (genvar c = 0; c < 4; c++) begin : g_out
    assign vbusEnable[c] = cur_r.hub_port_mode_word[2*c+1];
    assign dataEnable[c] = cur_r.hub_port_mode_word[2*c];
  end
  assign standardDataPort = 4'hF;
  assign edgeDownEnable   = 1'b1;
  assign typeADownEnable  = 1'b1;
  assign upstreamMiniB    = cur_r.upMiniB;
endmodule // port_rail_ctrl

// ### verif/port_rail_assertions.sv
// checker: port relations of the port and rail control block
// assumes a bind onto port_rail_ctrl, one clock, sync low reset
module port_rail_assertions (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       overTemperature,
  input wire logic [1:0] overVoltage,
  input wire logic [2:0] railEnable,
  input wire logic       linearRegEnable,
  input wire logic       switchRegEnable,
  input wire logic [3:0] serialEnable,
  input wire logic [3:0] serialDischarge,
  input wire logic [3:0] serialRailSelect,
  input wire logic [3:0] standardDataPort,
  input wire logic       edgeDownEnable,
  input wire logic       typeADownEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  AST_OT_LIN_OFF: assert property (overTemperature |-> !linearRegEnable)
    else $error("linear regulator on while hot");
  AST_OV_A: assert property (overVoltage[0] |-> !railEnable[1])
    else $error("rail a on during over-voltage");
  AST_OV_B: assert property (overVoltage[1] |-> !railEnable[2])
    else $error("rail b on during over-voltage");
  AST_ONE_REG: assert property (!(linearRegEnable && switchRegEnable))
    else $error("both regulators on");
  AST_DISCH: assert property ($rose(serialEnable[0]) |-> $fell(serialDischarge[0]))
    else $error("discharge not released with enable");
  AST_DISCH_ALL: assert property (serialDischarge == ~serialEnable)
    else $error("discharge not inverse of enable");
  AST_RAIL_PAIR: assert property (serialRailSelect == 4'hC)
    else $error("serial rail pairing wrong");
  AST_SDP: assert property (standardDataPort == 4'hF)
    else $error("port not standard data port");
  AST_ALWAYS_ON: assert property (edgeDownEnable && typeADownEnable)
    else $error("fixed downstream port off");
endmodule // port_rail_assertions

bind port_rail_ctrl port_rail_assertions chk_u (.ref_clk, .reset_n, .overTemperature,
  .overVoltage, .railEnable, .linearRegEnable, .switchRegEnable, .serialEnable,
  .serialDischarge, .serialRailSelect, .standardDataPort, .edgeDownEnable, .typeADownEnable);

// ### verif/apb_host_model.sv
// host model: apb master issuing the control transfers
// assumes pready comes within 16 cycles; raises hung otherwise
module apb_host_model (
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [7:0]       paddr = 8'h00,
  output logic [31:0]      pwdata = 32'h0000_0000,
  output logic             hung = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    if (i == 16) hung <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle bus shows the inverse so stale values are never mistaken for live ones
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host_model

// ### verif/testbench.sv
// testbench: reset values, register rows in a loop, then status and mid-run reset cases
// assumes the host model drives apb and the checker is bound
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import port_rail_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [7:0] r; logic [31:0] e;} row_t;
  logic        ref_clk = 0, reset_n = 0, psel, penable, pwrite, pready, pslverr, hung;
  logic        overTemperature = 0, miniBVbusPresent = 0, linearRegEnable, switchRegEnable;
  logic        edgeDownEnable, typeADownEnable, upstreamMiniB;
  logic [1:0]  overVoltage = 2'h0;
  logic [2:0]  railEnable;
  logic [3:0]  channelError = 4'h0, channelBoost = 4'h0, serialEnable, serialDischarge;
  logic [3:0]  serialRailSelect, vbusEnable, dataEnable, standardDataPort;
  logic [7:0]  paddr;
  logic [15:0] inputMillivolts = 16'h0000;
  logic [31:0] pwdata, prdata, railSetpointA, railSetpointB, q;
  logic [31:0] boardTemperature = 32'h0001_2345;
  int          n_fail = 0, checks = 0;
  row_t        rows [16] = '{
    '{OFF_RAIL_EN, 32'h0000_0007, OFF_RAIL_EN, 32'h0000_0007},
    '{OFF_REG_SEL, 32'h0000_0001, OFF_REG_SEL, 32'h0000_0001},
    '{OFF_REG_SEL, 32'h0000_0002, OFF_REG_SEL, 32'h0000_0002},
    '{OFF_RAIL_STAT, 32'hFFFF_FFFF, OFF_RAIL_STAT, 32'h0000_0001},
    '{OFF_SETPT_A, 32'h0123_4567, OFF_SETPT_A, 32'h0123_4567},
    '{OFF_SETPT_B, 32'h89AB_CDEF, OFF_SETPT_B, 32'h89AB_CDEF},
    '{OFF_SERIAL_EN, 32'h0000_0005, OFF_SERIAL_EN, 32'h0000_0005},
    '{OFF_UP_SEL, 32'h0000_0000, OFF_UP_SEL, 32'h0000_0000},
    '{OFF_UP_SEL, 32'h0000_0001, OFF_UP_SEL, 32'h0000_0001},
    '{OFF_UP_SEL, 32'h0000_0003, OFF_UP_SEL, 32'h0000_0001},
    '{8'h7C, 32'h0000_1234, 8'h7C, 32'h0000_0000},
    '{OFF_HUB_MODE, 32'hFFFF_FF96, OFF_HUB_MODE, 32'h0000_0096},
    '{OFF_CHAN_CMD, 32'h0000_0033, OFF_HUB_MODE, 32'h0000_0016},
    '{OFF_CHAN_CMD, 32'h0000_0010, OFF_HUB_MODE, 32'h0000_0014},
    '{OFF_CHAN_CMD, 32'h0000_0123, OFF_HUB_MODE, 32'h0000_0054},
    '{OFF_CHAN_CMD, 32'h0000_0131, OFF_HUB_MODE, 32'h0000_005C}};

  port_rail_ctrl dut_u (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .inputMillivolts, .boardTemperature, .overTemperature,
    .overVoltage, .miniBVbusPresent, .channelError, .channelBoost, .railEnable,
    .linearRegEnable, .switchRegEnable, .railSetpointA, .railSetpointB, .serialEnable,
    .serialDischarge, .serialRailSelect, .vbusEnable, .dataEnable, .standardDataPort,
    .edgeDownEnable, .typeADownEnable, .upstreamMiniB);
  apb_host_model host_u (.ref_clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr,
    .pwdata, .hung);

  always #2 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a hung transfer counts as a mismatch
  always @(posedge hung) begin
    n_fail++;
    finish_test;
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    host_u.xfer(1'b0, OFF_REG_SEL, 32'h0000_0000, q);
    chk(q, {30'h0, REG_SEL_AUTO});
    host_u.xfer(1'b0, OFF_UP_SEL, 32'h0000_0000, q);
    chk(q, {30'h0, UP_SEL_AUTO});
    host_u.xfer(1'b0, OFF_TEMP, 32'h0000_0000, q);
    chk(q, boardTemperature);
    chk({serialDischarge, vbusEnable, dataEnable}, 12'hF00);
    $display("reset test done");
    foreach (rows[i]) begin
      host_u.xfer(1'b1, rows[i].a, rows[i].d, q);
      host_u.xfer(1'b0, rows[i].r, 32'h0000_0000, q);
      chk(q, rows[i].e);
    end
    chk({railEnable, serialEnable, vbusEnable, dataEnable, upstreamMiniB,
         switchRegEnable, linearRegEnable}, 18'h3_A976);
    chk({railSetpointA ^ railSetpointB}, 32'h8888_8888);
    $display("register rows done");
    host_u.xfer(1'b1, OFF_REG_SEL, {30'h0, REG_SEL_AUTO}, q);
    inputMillivolts <= 16'h1C52;
    host_u.xfer(1'b0, OFF_REG_STATE, 32'h0000_0000, q);
    chk(q[15:8], REG_ACT_LINEAR);
    inputMillivolts <= 16'h1C53;
    host_u.xfer(1'b0, OFF_REG_STATE, 32'h0000_0000, q);
    chk({q[15:8], switchRegEnable}, {REG_ACT_SWITCH, 1'b1});
    host_u.xfer(1'b1, OFF_REG_SEL, {30'h0, REG_SEL_LINEAR}, q);
    overTemperature <= 1'b1;
    overVoltage <= 2'h3;
    host_u.xfer(1'b1, OFF_UP_SEL, {30'h0, UP_SEL_AUTO}, q);
    // the auto choice reaches the pin one edge after the write lands
    repeat (2) @(posedge ref_clk);
    chk({linearRegEnable, railEnable, upstreamMiniB}, 5'h02);
    overTemperature <= 1'b0;
    overVoltage <= 2'h0;
    miniBVbusPresent <= 1'b1;
    channelError <= 4'h2;
    channelBoost <= 4'h2;
    host_u.xfer(1'b0, OFF_UP_STATE, 32'h0000_0000, q);
    chk({pslverr, q[0], linearRegEnable, railEnable, upstreamMiniB}, 7'h3F);
    host_u.xfer(1'b0, OFF_CHAN_STATE0 + 8'h04, 32'h0000_0000, q);
    chk(q, 32'h0018_0003);
    $display("status tests done");
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk({railEnable, serialEnable, serialDischarge, vbusEnable, dataEnable, switchRegEnable,
         linearRegEnable}, 21'h00_3C00);
    chk(railSetpointA | railSetpointB, 32'h0000_0000);
    host_u.xfer(1'b0, OFF_REG_SEL, 32'h0000_0000, q);
    chk(q, {30'h0, REG_SEL_AUTO});
    $display("mid-run reset test done");
    finish_test;
  end
endmodule // testbench
